// ### common/hrwh_pkg.sv
// constants, types and wait lookups for the host-side port sequencer
// assumes a 250 MHz host clock and a 16-bit asynchronous sram-like device
package hrwh_pkg;

  localparam int CLK_PERIOD_NS = 4;

  // least times round up to whole clock cycles
  function automatic int ns_cyc_up(input int ns);
    return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  endfunction

  // pin cycle timing
  localparam int T_CSL_NS = 32;
  localparam int T_CSH_NS = 13;
  localparam int T_CSDV_NS = 30;
  localparam int T_CYCLE_NS = 45;
  localparam int SYNC_STAGES = 3;
  localparam logic [3:0] RD_LOW_CYC =
    4'(ns_cyc_up(T_CSDV_NS) + SYNC_STAGES);
  localparam logic [3:0] WR_LOW_CYC = 4'(ns_cyc_up(T_CSL_NS));
  localparam logic [3:0] REL_CYC = 4'(ns_cyc_up(T_CSH_NS));

  // read-after-write waits
  localparam int WAIT_CTRL_NS = 45;
  localparam int WAIT_ISTS_NS = 90;
  localparam int WAIT_MID_NS = 135;
  localparam int WAIT_FRUN_NS = 180;
  localparam int WAIT_PMT_NS = 315;
  localparam logic [6:0] WAIT_NONE_CYC = 7'h00;
  localparam logic [6:0] WAIT_CTRL_CYC = 7'(ns_cyc_up(WAIT_CTRL_NS));
  localparam logic [6:0] WAIT_ISTS_CYC = 7'(ns_cyc_up(WAIT_ISTS_NS));
  localparam logic [6:0] WAIT_MID_CYC = 7'(ns_cyc_up(WAIT_MID_NS));
  localparam logic [6:0] WAIT_FRUN_CYC = 7'(ns_cyc_up(WAIT_FRUN_NS));
  localparam logic [6:0] WAIT_PMT_CYC = 7'(ns_cyc_up(WAIT_PMT_NS));
  localparam logic [6:0] ELAPSED_MAX = WAIT_PMT_CYC;
  localparam logic [2:0] DUMMY_MAX = 3'h7;

  // register index = address bits [6:1]; half select is bit 0
  localparam logic [5:0] IDX_CHIP_ID = 6'h00;
  localparam logic [5:0] IDX_IRQ_CFG = 6'h01;
  localparam logic [5:0] IDX_INTERRUPT_STATUS_REG = 6'h02;
  localparam logic [5:0] IDX_INT_EN = 6'h03;
  localparam logic [5:0] IDX_ENDIAN = 6'h04;
  localparam logic [5:0] IDX_FIFO_INT = 6'h05;
  localparam logic [5:0] IDX_RX_CFG = 6'h06;
  localparam logic [5:0] IDX_TX_CFG = 6'h07;
  localparam logic [5:0] IDX_HARDWARE_CONFIG = 6'h08;
  localparam logic [5:0] IDX_RX_DP = 6'h09;
  localparam logic [5:0] IDX_RX_INFO = 6'h0A;
  localparam logic [5:0] IDX_TX_INFO = 6'h0B;
  localparam logic [5:0] IDX_PMT = 6'h0C;
  localparam logic [5:0] IDX_GPIO = 6'h0D;
  localparam logic [5:0] IDX_GP_TIMER_CONFIG = 6'h0E;
  localparam logic [5:0] IDX_GP_TIMER_COUNT = 6'h0F;
  localparam logic [5:0] IDX_WSWAP = 6'h10;
  localparam logic [5:0] IDX_FREE_RUN = 6'h11;
  localparam logic [5:0] IDX_RX_DROP = 6'h12;
  localparam logic [5:0] IDX_MAC_CMD = 6'h13;
  localparam logic [5:0] IDX_MAC_DATA = 6'h14;
  localparam logic [5:0] IDX_FLOW = 6'h15;
  localparam logic [5:0] IDX_EE_CMD = 6'h16;
  localparam logic [5:0] IDX_EE_DATA = 6'h17;
  localparam logic [5:0] IDX_TX_FIFO = 6'h18;

  // wait in cycles before reading a register, keyed on the read target
  function automatic logic [6:0] wait_cyc(input logic [5:0] idx);
    case (idx)
      IDX_CHIP_ID, IDX_ENDIAN, IDX_RX_INFO, IDX_RX_DROP:
        wait_cyc = WAIT_NONE_CYC;
      IDX_INT_EN, IDX_FIFO_INT, IDX_RX_CFG, IDX_TX_CFG, IDX_HARDWARE_CONFIG,
      IDX_RX_DP, IDX_GPIO, IDX_GP_TIMER_CONFIG, IDX_WSWAP, IDX_MAC_CMD,
      IDX_MAC_DATA, IDX_FLOW, IDX_EE_CMD, IDX_EE_DATA:
        wait_cyc = WAIT_CTRL_CYC;
      IDX_IRQ_CFG: wait_cyc = WAIT_MID_CYC;
      IDX_INTERRUPT_STATUS_REG: wait_cyc = WAIT_ISTS_CYC;
      IDX_PMT: wait_cyc = WAIT_PMT_CYC;
      IDX_FREE_RUN: wait_cyc = WAIT_FRUN_CYC;
      IDX_GP_TIMER_COUNT: wait_cyc = WAIT_MID_CYC;
      IDX_TX_INFO: wait_cyc = WAIT_MID_CYC;
      default: wait_cyc = WAIT_PMT_CYC; // unknown: take the worst case
    endcase
  endfunction

  // dummy endian reads that stand in for the same wait
  function automatic logic [2:0] dummy_cnt(input logic [5:0] idx);
    case (idx)
      IDX_CHIP_ID, IDX_ENDIAN, IDX_RX_INFO, IDX_RX_DROP:
        dummy_cnt = 3'h0;
      IDX_IRQ_CFG, IDX_GP_TIMER_COUNT, IDX_TX_INFO:
        dummy_cnt = 3'h3;
      IDX_INTERRUPT_STATUS_REG: dummy_cnt = 3'h2;
      IDX_PMT: dummy_cnt = 3'h7;
      IDX_FREE_RUN: dummy_cnt = 3'h4;
      IDX_INT_EN, IDX_FIFO_INT, IDX_RX_CFG, IDX_TX_CFG, IDX_HARDWARE_CONFIG,
      IDX_RX_DP, IDX_GPIO, IDX_GP_TIMER_CONFIG, IDX_WSWAP, IDX_MAC_CMD,
      IDX_MAC_DATA, IDX_FLOW, IDX_EE_CMD, IDX_EE_DATA:
        dummy_cnt = 3'h1;
      default: dummy_cnt = DUMMY_MAX;
    endcase
  endfunction

  // user command: one 16-bit access
  typedef struct packed {
    logic write;
    logic [6:0] addr;
    logic [15:0] data;
  } hrwh_cmd_t;

  // device-facing pins, all registered
  typedef struct packed {
    logic chip_select_n;
    logic read_strobe_n;
    logic write_strobe_n;
    logic [6:0] addr;
    logic [15:0] dq_out;
    logic dq_oe;
  } hrwh_pins_t;

  localparam hrwh_pins_t PINS_IDLE = '{
    chip_select_n: 1'b1, read_strobe_n: 1'b1, write_strobe_n: 1'b1,
    addr: 7'h00, dq_out: 16'h0000, dq_oe: 1'b0};

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_HOLD = 5'h02,
    ST_SETUP = 5'h04,
    ST_ASSERT = 5'h08,
    ST_RELEASE = 5'h10
  } hrwh_state_t;

endpackage

// ### rtl/hrwh_host.sv
// host-side sequencer driving an sram-like 16-bit device port
// assumes user logic on clk_in; device pins are asynchronous to it
module hrwh_host
  import hrwh_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // user command side
  input wire logic cmd_valid_in,
  input wire hrwh_cmd_t cmd_in,
  input wire logic dummy_mode_in,
  output logic cmd_ready_out,
  output logic rsp_valid_out,
  output logic [15:0] rsp_data_out,
  output logic [2:0] dummy_reads_out,
  // device pins
  output hrwh_pins_t pins_out,
  input wire logic [15:0] dq_in
);

  // read data synchroniser state
  logic [15:0] dq_s1;
  logic [15:0] dq_s2;
  logic [15:0] dq_s3;
  logic [15:0] next_dq_s1;
  logic [15:0] next_dq_s2;
  logic [15:0] next_dq_s3;

  // sequencer state
  hrwh_state_t state;
  hrwh_state_t next_state;
  hrwh_cmd_t cmd;
  hrwh_cmd_t next_cmd;
  hrwh_pins_t pins;
  hrwh_pins_t next_pins;
  logic [3:0] phase;
  logic [3:0] next_phase;
  logic is_dummy;
  logic next_is_dummy;
  logic since_wr;
  logic next_since_wr;
  logic [6:0] elapsed;
  logic [6:0] next_elapsed;
  logic [2:0] ndummy;
  logic [2:0] next_ndummy;
  logic ready;
  logic next_ready;
  logic rsp_valid;
  logic next_rsp_valid;
  logic [15:0] rsp_data;
  logic [15:0] next_rsp_data;
  logic [2:0] dummy_reads;
  logic [2:0] next_dummy_reads;

  // wait decision terms for the held command
  logic sat_time;
  logic sat_dummy;

  // three-stage chain; only stages two and three are compared
  always_comb begin
    next_dq_s1 = dq_in;
    next_dq_s2 = dq_s1;
    next_dq_s3 = dq_s2;
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      dq_s1 <= 16'h0000;
      dq_s2 <= 16'h0000;
      dq_s3 <= 16'h0000;
    end else begin
      dq_s1 <= next_dq_s1;
      dq_s2 <= next_dq_s2;
      dq_s3 <= next_dq_s3;
    end
  end

  // wait is keyed on the register about to be read
  always_comb begin
    sat_time = !since_wr || (elapsed >= wait_cyc(cmd.addr[6:1]));
    sat_dummy = since_wr && (ndummy >= dummy_cnt(cmd.addr[6:1]));
  end

  // access sequencing
  always_comb begin
    next_state = state;
    next_cmd = cmd;
    next_pins = pins;
    next_phase = phase;
    next_is_dummy = is_dummy;
    next_since_wr = since_wr;
    next_ndummy = ndummy;
    next_ready = ready;
    next_rsp_valid = 1'b0;
    next_rsp_data = rsp_data;
    next_dummy_reads = dummy_reads;
    // time since the last write, saturating at the longest wait
    next_elapsed = (elapsed < ELAPSED_MAX) ? 7'(elapsed + 7'h01) : elapsed;
    case (state)
      ST_IDLE: begin
        if (cmd_valid_in) begin
          next_cmd = cmd_in;
          next_ready = 1'b0;
          next_dummy_reads = 3'h0;
          next_state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        // writes never wait; reads wait for time or enough dummies
        if (cmd.write || sat_time || (dummy_mode_in && sat_dummy)) begin
          next_pins.addr = cmd.addr;
          next_pins.dq_out = cmd.data;
          next_pins.dq_oe = cmd.write;
          next_is_dummy = 1'b0;
          next_state = ST_SETUP;
        end else if (dummy_mode_in) begin
          // slow dummy cycles end the wait early once time is met
          next_pins.addr = {IDX_ENDIAN, 1'b0};
          next_pins.dq_oe = 1'b0;
          next_is_dummy = 1'b1;
          next_state = ST_SETUP;
        end
      end
      ST_SETUP: begin
        // address and write data settle one cycle ahead of the strobes
        next_pins.chip_select_n = 1'b0;
        next_pins.read_strobe_n = cmd.write && !is_dummy;
        next_pins.write_strobe_n = !(cmd.write && !is_dummy);
        next_phase = 4'h0;
        next_state = ST_ASSERT;
      end
      ST_ASSERT: begin
        next_phase = 4'(phase + 4'h1);
        if (!pins.write_strobe_n) begin
          if (phase >= 4'(WR_LOW_CYC - 4'h1)) begin
            next_pins.chip_select_n = 1'b1;
            next_pins.write_strobe_n = 1'b1;
            next_phase = 4'h0;
            // restart the hold-off at the end of every write
            next_since_wr = 1'b1;
            next_elapsed = 7'h00;
            next_ndummy = 3'h0;
            next_state = ST_RELEASE;
          end
        end else if ((phase >= 4'(RD_LOW_CYC - 4'h1)) &&
                     (dq_s2 == dq_s3)) begin
          // the bus is held until two stages agree, so data is settled
          if (!is_dummy) begin
            next_rsp_data = dq_s3;
          end
          next_pins.chip_select_n = 1'b1;
          next_pins.read_strobe_n = 1'b1;
          next_phase = 4'h0;
          next_state = ST_RELEASE;
        end
      end
      ST_RELEASE: begin
        next_phase = 4'(phase + 4'h1);
        if (phase >= 4'(REL_CYC - 4'h1)) begin
          next_pins.dq_oe = 1'b0;
          if (is_dummy) begin
            if (ndummy < DUMMY_MAX) begin
              next_ndummy = 3'(ndummy + 3'h1);
            end
            if (dummy_reads < DUMMY_MAX) begin
              next_dummy_reads = 3'(dummy_reads + 3'h1);
            end
            next_state = ST_HOLD;
          end else begin
            next_rsp_valid = 1'b1;
            next_ready = 1'b1;
            next_state = ST_IDLE;
          end
        end
      end
      default: begin
        next_pins = PINS_IDLE;
        next_ready = 1'b1;
        next_state = ST_IDLE;
      end
    endcase
  end

  // register the sequencer state
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      state <= ST_IDLE;
      cmd <= '0;
      pins <= PINS_IDLE;
      phase <= 4'h0;
      is_dummy <= 1'b0;
      since_wr <= 1'b0;
      elapsed <= 7'h00;
      ndummy <= 3'h0;
      ready <= 1'b1;
      rsp_valid <= 1'b0;
      rsp_data <= 16'h0000;
      dummy_reads <= 3'h0;
    end else begin
      state <= next_state;
      cmd <= next_cmd;
      pins <= next_pins;
      phase <= next_phase;
      is_dummy <= next_is_dummy;
      since_wr <= next_since_wr;
      elapsed <= next_elapsed;
      ndummy <= next_ndummy;
      ready <= next_ready;
      rsp_valid <= next_rsp_valid;
      rsp_data <= next_rsp_data;
      dummy_reads <= next_dummy_reads;
    end
  end

  // outputs come straight from flip-flops
  assign cmd_ready_out = ready;
  assign rsp_valid_out = rsp_valid;
  assign rsp_data_out = rsp_data;
  assign dummy_reads_out = dummy_reads;
  assign pins_out = pins;

endmodule

// ### bench/hrwh_host_asserts.sv
// checker for read-after-write spacing on the host port
// assumes binding onto hrwh_host; sees only its ports
module hrwh_host_asserts
  import hrwh_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // command side
  input wire logic cmd_valid_in,
  input wire hrwh_cmd_t cmd_in,
  input wire logic cmd_ready_out,
  input wire logic rsp_valid_out,
  input wire logic [2:0] dummy_reads_out,
  // device pins
  input wire hrwh_pins_t pins_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  logic [8:0] since_wr;
  logic [5:0] cur_idx;
  logic cs_n, rd_n, wr_n;
  assign cs_n = pins_out.chip_select_n;
  assign rd_n = pins_out.read_strobe_n;
  assign wr_n = pins_out.write_strobe_n;

  // least ns before reading idx after any write
  function automatic int need_ns(input logic [5:0] idx);
    case (idx)
      IDX_CHIP_ID, IDX_ENDIAN, IDX_RX_INFO, IDX_RX_DROP: return 0;
      IDX_IRQ_CFG, IDX_GP_TIMER_COUNT, IDX_TX_INFO: return 135;
      IDX_INTERRUPT_STATUS_REG: return 90;
      IDX_FREE_RUN: return 180;
      IDX_PMT: return 315;
      default: return 45;
    endcase
  endfunction

  // cycles since a write strobe rose; saturated means none pending
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) since_wr <= 9'h1FF;
    else if (!wr_n) since_wr <= 9'h000;
    else if (since_wr != 9'h1FF) since_wr <= since_wr + 9'h001;
    if (cmd_valid_in && cmd_ready_out) cur_idx <= cmd_in.addr[6:1];
  end

  a_raw_wait_met: assert property (
    $fell(rd_n) && !cs_n |-> int'(since_wr) * 4 >= need_ns(pins_out.addr[6:1]))
    else $error("read started before its wait after a write");
  a_dummy_cap: assert property (
    rsp_valid_out |-> int'(dummy_reads_out) <= need_ns(cur_idx) / 45)
    else $error("more dummy reads than the wait needs");
  a_dummy_endian: assert property (
    $fell(rd_n) && pins_out.addr[6:1] != cur_idx
      |-> pins_out.addr[6:1] == IDX_ENDIAN)
    else $error("filler read not aimed at the endian register");
  a_write_qual: assert property (!wr_n |-> !cs_n)
    else $error("write strobe without chip select");
  a_wr_low_len: assert property (
    $fell(wr_n) |-> (!wr_n) [*8] ##1 wr_n)
    else $error("write strobe low time wrong");
  a_wr_bus_driven: assert property (
    !wr_n |-> pins_out.dq_oe && $stable(pins_out.dq_out))
    else $error("write data not driven steadily");
  a_write_done: assert property (
    cmd_valid_in && cmd_ready_out && cmd_in.write |-> ##[13:16] rsp_valid_out)
    else $error("write not answered in time");
  a_addr_stable: assert property (
    !cs_n && !$past(cs_n) |-> $stable(pins_out.addr))
    else $error("address moved during a cycle");
  c_filler: cover property ($fell(rd_n) && pins_out.addr[6:1] == IDX_ENDIAN);
  c_long: cover property (rsp_valid_out && cur_idx == IDX_PMT);
  c_write: cover property ($fell(wr_n));
endmodule

bind hrwh_host hrwh_host_asserts u_asserts (
  .clk_in(clk_in), .sys_rst_in(sys_rst_in), .cmd_valid_in(cmd_valid_in),
  .cmd_in(cmd_in), .cmd_ready_out(cmd_ready_out),
  .rsp_valid_out(rsp_valid_out), .dummy_reads_out(dummy_reads_out),
  .pins_out(pins_out));

// ### bench/hrwh_dev_model.sv
// behavioural device behind the host port: storage and stale reads
// assumes pins from hrwh_host and the resolved data wire from the bench
module hrwh_dev_model
  import hrwh_pkg::*;
#(
  parameter logic [15:0] ID_VALUE = 16'h5A3C, // arbitrary value
  parameter logic [15:0] ENDIAN_VALUE = 16'h8765
)(
  // clock
  input wire logic clk_in,
  // host pins and resolved data wire
  input wire hrwh_pins_t pins_in,
  input wire logic [15:0] bus_in,
  output logic [15:0] dev_dq_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] mem [0:127];
  logic [15:0] rd_val, junk, cur;
  logic [8:0] since;
  logic [2:0] lowc;
  logic wr_act, rd_act, wr_prev, rd_prev;
  assign wr_act = !pins_in.chip_select_n && !pins_in.write_strobe_n;
  assign rd_act = !pins_in.chip_select_n && !pins_in.read_strobe_n;
  assign cur = (pins_in.addr[6:1] == IDX_CHIP_ID) ? ID_VALUE :
    (pins_in.addr[6:1] == IDX_ENDIAN) ? ENDIAN_VALUE : mem[pins_in.addr];
  // valid only after the access time; a moving pattern otherwise
  assign dev_dq_out = (rd_act && lowc == 3'h6) ? rd_val : junk;

  // permitted lag of each register after any write
  function automatic int lag_ns(input logic [5:0] idx);
    case (idx)
      IDX_CHIP_ID, IDX_ENDIAN, IDX_RX_INFO, IDX_RX_DROP: return 0;
      IDX_IRQ_CFG, IDX_GP_TIMER_COUNT: return 135;
      IDX_TX_INFO: return 135;
      IDX_INTERRUPT_STATUS_REG: return 90;
      IDX_FREE_RUN: return 180;
      IDX_PMT: return 315;
      default: return 45;
    endcase
  endfunction

  initial begin
    for (int i = 0; i < 128; i++) mem[i] = 16'h0000;
    junk = 16'h1234;
    since = 9'h1FF;
    lowc = 3'h0;
    wr_prev = 1'b0;
    rd_prev = 1'b0;
  end

  // writes land as the cycle ends; early reads see stale data
  always @(posedge clk_in) begin
    junk <= {junk[14:0], ~junk[15]};
    wr_prev <= wr_act;
    rd_prev <= rd_act;
    if (wr_act) since <= 9'h000;
    else if (since != 9'h1FF) since <= since + 9'h001;
    if (wr_prev && !wr_act) begin
      case (pins_in.addr[6:1])
        IDX_TX_FIFO: mem[{IDX_TX_INFO, 1'b0}] <=
          mem[{IDX_TX_INFO, 1'b0}] + 16'h0001;
        IDX_CHIP_ID, IDX_ENDIAN, IDX_TX_INFO: ;
        default: mem[pins_in.addr] <= bus_in;
      endcase
    end
    if (rd_act && !rd_prev) begin
      lowc <= 3'h0;
      // stale value until the register's permitted lag has run out
      rd_val <= (int'(since) * 4 < lag_ns(pins_in.addr[6:1])) ?
        ~cur : cur;
    end else if (rd_act && lowc != 3'h6) lowc <= lowc + 3'h1;
  end
endmodule

// ### bench/hrwh_host_tb_top.sv
// self-checking bench for the host port sequencer
// assumes hrwh_host, hrwh_dev_model and the bound checker
module hrwh_host_tb_top
  import hrwh_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [15:0] ID_VALUE = 16'h5A3C; // arbitrary value
  localparam logic [15:0] ENDIAN_VALUE = 16'h8765;
  logic clk_in, sys_rst_in, cmd_valid_in, dummy_mode_in;
  logic cmd_ready_out, rsp_valid_out;
  hrwh_cmd_t cmd_in;
  hrwh_pins_t pins;
  logic [15:0] rsp_data_out, dev_dq, dq_wire;
  logic [2:0] dummy_reads_out;
  logic [15:0] shadow [0:127];
  logic [20:0] exp_q [$];
  logic [31:0] seed;
  logic [5:0] tgt [10];
  int num_errors, n_checks, cyc;

  // host drives the wire only while its enable is high
  assign dq_wire = pins.dq_oe ? pins.dq_out : dev_dq;

  hrwh_host dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in),
    .dummy_mode_in(dummy_mode_in), .cmd_ready_out(cmd_ready_out),
    .rsp_valid_out(rsp_valid_out), .rsp_data_out(rsp_data_out),
    .dummy_reads_out(dummy_reads_out), .pins_out(pins), .dq_in(dq_wire));
  hrwh_dev_model #(.ID_VALUE(ID_VALUE), .ENDIAN_VALUE(ENDIAN_VALUE)) u_dev (
    .clk_in(clk_in), .pins_in(pins), .bus_in(dq_wire), .dev_dq_out(dev_dq));

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // most dummy reads that a read may need after a write
  function automatic logic [2:0] need_rd(input logic [5:0] idx);
    case (idx)
      IDX_CHIP_ID, IDX_ENDIAN, IDX_RX_INFO, IDX_RX_DROP: return 3'h0;
      IDX_IRQ_CFG, IDX_GP_TIMER_COUNT, IDX_TX_INFO: return 3'h3;
      IDX_INTERRUPT_STATUS_REG: return 3'h2;
      IDX_FREE_RUN: return 3'h4;
      IDX_PMT: return 3'h7;
      default: return 3'h1;
    endcase
  endfunction

  task automatic wrap_up();
    // an access that never answered leaves its note behind
    if (exp_q.size() != 0) begin
      num_errors++;
      $display("CHECK FAILED exp_q size exp 0 got %0d", exp_q.size());
    end
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // one access: note the expectation, hold until taken, await answer
  task automatic acc(input logic w, input logic [6:0] a,
                     input logic [15:0] d, input logic dm);
    logic [15:0] e;
    logic [2:0] c;
    e = (a[6:1] == IDX_CHIP_ID) ? ID_VALUE :
      (a[6:1] == IDX_ENDIAN) ? ENDIAN_VALUE : shadow[a];
    c = w ? 3'h0 : need_rd(a[6:1]);
    exp_q.push_back({w, dm, c, e});
    if (w && a[6:1] == IDX_TX_FIFO) shadow[{IDX_TX_INFO, 1'b0}] += 16'h0001;
    else if (w && !(a[6:1] inside {IDX_CHIP_ID, IDX_ENDIAN, IDX_TX_INFO}))
      shadow[a] = d;
    @(negedge clk_in);
    cmd_valid_in = 1'b1;
    cmd_in = '{write: w, addr: a, data: d};
    dummy_mode_in = dm;
    for (int n = 0; n < 200 && cmd_ready_out !== 1'b1; n++) @(negedge clk_in);
    @(negedge clk_in);
    cmd_valid_in = 1'b0;
    for (int n = 0; n < 400 && rsp_valid_out !== 1'b1; n++) @(negedge clk_in);
  endtask

  // response watcher: oldest note against each answer
  always @(negedge clk_in) begin
    logic [20:0] e;
    if (rsp_valid_out === 1'b1) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 21'h00FFFF;
      n_checks++;
      if (!e[20] && rsp_data_out !== e[15:0]) begin
        num_errors++;
        $display("CHECK FAILED rsp_data_out exp %h got %h", e[15:0],
          rsp_data_out);
      end
      // never more dummies than the table, none in idle-wait mode
      if ($isunknown(dummy_reads_out) || dummy_reads_out > e[18:16] ||
          (!e[19] && dummy_reads_out != 3'h0)) begin
        num_errors++;
        $display("CHECK FAILED dummy_reads_out exp max %h got %h",
          e[19] ? e[18:16] : 3'h0, dummy_reads_out);
      end
      // every nonzero wait outlasts the gap the bench leaves after a write
      if (!e[20] && e[19] && e[18:16] != 3'h0 &&
          dummy_reads_out == 3'h0) begin
        num_errors++;
        $display("CHECK FAILED dummy_reads_out exp min 1 got %h",
          dummy_reads_out);
      end
    end
  end

  // hang guard, well above the expected run length
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 30000) begin
      num_errors++;
      wrap_up();
    end
  end

  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  // each target in both wait styles: write it (IDX_TX_FIFO in place of IDX_TX_INFO), write another, read it
  initial begin
    logic [6:0] wa;
    sys_rst_in = 1'b1;
    cmd_valid_in = 1'b0;
    cmd_in = '0;
    dummy_mode_in = 1'b0;
    seed = 32'h83ED;
    for (int i = 0; i < 128; i++) shadow[i] = 16'h0000;
    tgt = '{IDX_IRQ_CFG, IDX_INTERRUPT_STATUS_REG, IDX_PMT, IDX_FREE_RUN, IDX_GP_TIMER_COUNT,
      IDX_TX_INFO, IDX_GPIO, IDX_CHIP_ID, IDX_ENDIAN, IDX_RX_DROP};
    repeat (20) @(negedge clk_in);
    sys_rst_in = 1'b0;
    for (int m = 0; m < 2; m++) begin
      for (int i = 0; i < 10; i++) begin
        seed = lfsr_next(seed);
        wa = {tgt[i], seed[16]};
        if (tgt[i] == IDX_TX_INFO) wa = {IDX_TX_FIFO, 1'b0};
        acc(1'b1, wa, seed[15:0], m[0]);
        acc(1'b1, {IDX_EE_CMD, 1'b0}, seed[31:16], m[0]);
        if (tgt[i] == IDX_TX_INFO) wa = {IDX_TX_INFO, 1'b0};
        acc(1'b0, wa, 16'h0000, m[0]);
      end
    end
    // let the watcher take the last answer before the verdict
    repeat (2) @(negedge clk_in);
    wrap_up();
  end
endmodule
